// ==== hdl/pxc2_regs.sv ====
// Purpose: Second extended control and status register and the logic it steers.
// Assumes: Management decoding upstream gives one-cycle write and read strobes.
// Notes: Strap levels are caught on the third clock after reset release.
module pxc2_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic node_repeater_strap,
  input wire logic pin_register_priority_strap,
  input wire logic partner_remote_fault,
  input wire logic isolate,
  input wire logic speed_10m,
  input wire logic full_duplex,
  input wire logic sqe_inhibit,
  input wire logic tx_en,
  input wire logic tx_activity,
  input wire logic rx_activity,
  output logic tx_pair_high_impedance,
  output logic tx_pair_positive_oe_n,
  output logic tx_pair_negative_oe_n,
  output logic tx100_power_down,
  output logic carrier_sense,
  output logic collision_sqe
);
  logic [1:0] strap_sync;
  logic node_repeater_reg;
  logic priority_reg;
  logic strap_taken_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] read_value;
  logic tx_en_d_reg;
  logic [3:0] sqe_cnt_reg;
  logic [3:0] sqe_cnt_next;
  logic [1:0] pair_oe_n;

  // One decode serves the write path, the read strobe and the read data.
  function automatic logic reg_hit(input logic strobe, input logic [4:0] addr);
    return strobe && addr == pxc2_pkg::REG_ADDR;
  endfunction : reg_hit

  // Straps are pins, so they are synchronised before capture.
  pxc2_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({node_repeater_strap, pin_register_priority_strap}),
    .sync_out(strap_sync)
  );

  // Capture once after the synchroniser has settled following release.
  logic [1:0] settle_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // Capturing only once keeps the strap bits steady if a pin moves later.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_taken_reg <= 1'b0;
      node_repeater_reg <= 1'b0;
      priority_reg <= 1'b0;
    end else if (settle_reg == 2'h2 && !strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      node_repeater_reg <= strap_sync[1];
      priority_reg <= strap_sync[0];
    end
  end

  // Only writable bits change; status bits ignore writes.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= pxc2_pkg::RESET_VALUE;
    end else if (reg_hit(mgmt_wr, mgmt_addr)) begin
      ctrl_reg <= mgmt_wdata & pxc2_pkg::RW_MASK;
    end
  end

  logic fault_sync;
  pxc2_sync #(.W(1)) u_fault (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(partner_remote_fault),
    .sync_out(fault_sync)
  );

  always_comb begin
    read_value = ctrl_reg;
    read_value[pxc2_pkg::BIT_NODE_REP] = node_repeater_reg;
    read_value[pxc2_pkg::BIT_PRIORITY] = priority_reg;
    read_value[pxc2_pkg::BIT_REMOTE_FAULT] = fault_sync;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= reg_hit(mgmt_rd, mgmt_addr);
    end
  end

  // Read data is a snapshot taken with the strobe and held until the next read of this register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (reg_hit(mgmt_rd, mgmt_addr)) begin
      mgmt_rdata <= read_value;
    end
  end

  // Output enables are active low; high impedance when bit 7 is set.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_pair_high_impedance <= 1'b0;
    end else begin
      tx_pair_high_impedance <= ctrl_reg[pxc2_pkg::BIT_TX_HIGHZ];
    end
  end

  // Both legs of the pair share one control, so one loop builds both enables.
  for (genvar g = 0; g < 2; g++) begin : g_pair_oe
    logic oe_n_reg;
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        oe_n_reg <= 1'b0;
      end else begin
        oe_n_reg <= ctrl_reg[pxc2_pkg::BIT_TX_HIGHZ];
      end
    end
    assign pair_oe_n[g] = oe_n_reg;
  end

  assign tx_pair_positive_oe_n = pair_oe_n[0];
  assign tx_pair_negative_oe_n = pair_oe_n[1];

  // The 100M block sleeps at 10M when enabled, and always while isolated.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx100_power_down <= 1'b0;
    end else begin
      tx100_power_down <= (ctrl_reg[pxc2_pkg::BIT_AUTO_PD] && speed_10m)
        || isolate;
    end
  end

  // Repeaters must not see their own transmissions as carrier.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      carrier_sense <= 1'b0;
    end else if (node_repeater_reg) begin
      carrier_sense <= rx_activity;
    end else begin
      carrier_sense <= rx_activity || tx_activity;
    end
  end

  // SQE is off in repeater and full-duplex operation, whatever the inhibit bit.
  logic sqe_enabled;
  assign sqe_enabled = !node_repeater_reg && !full_duplex && !sqe_inhibit;

  always_comb begin
    sqe_cnt_next = sqe_cnt_reg;
    if (tx_en_d_reg && !tx_en && sqe_enabled) begin
      sqe_cnt_next = 4'(pxc2_pkg::SQE_DELAY_CYCLES + pxc2_pkg::SQE_PULSE_CYCLES);
    end else if (sqe_cnt_reg != 4'h0) begin
      sqe_cnt_next = sqe_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_en_d_reg <= 1'b0;
    end else begin
      tx_en_d_reg <= tx_en;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sqe_cnt_reg <= 4'h0;
    end else begin
      sqe_cnt_reg <= sqe_cnt_next;
    end
  end

  // The pulse is the low part of the count, after the delay has run down.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      collision_sqe <= 1'b0;
    end else begin
      collision_sqe <= sqe_cnt_next != 4'h0
        && sqe_cnt_next <= 4'(pxc2_pkg::SQE_PULSE_CYCLES);
    end
  end
endmodule : pxc2_regs

// ==== shared/pxc2_pkg.sv ====
// Purpose: Constants for the second extended control and status register.
// Assumes: Register reached by a management write/read strobe with a 5-bit register address.
// Notes: Field positions and reset values are shared by design and bench.
package pxc2_pkg;
  localparam logic [4:0] REG_ADDR = 5'h13;
  localparam int BIT_NODE_REP = 15;
  localparam int BIT_PRIORITY = 14;
  localparam int BIT_REMOTE_FAULT = 13;
  localparam int BIT_TX_HIGHZ = 7;
  localparam int BIT_AUTO_PD = 0;
  localparam logic [15:0] RW_MASK = 16'h1bff;
  localparam logic [15:0] RESET_VALUE = 16'h0001;
  localparam int SQE_PULSE_CYCLES = 4;
  localparam int SQE_DELAY_CYCLES = 2;
endpackage : pxc2_pkg

// ==== hdl/pxc2_sync.sv ====
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Single clock, synchronous active-low reset.
// Notes: The first stage feeds only the second.
module pxc2_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pxc2_sync

// ==== tb/pxc2_mgr.sv ====
// Purpose: Management entity model.
// Assumes: Drives on falling edges.
// Notes: Released strobes drop low; address and data lines show the inverse.
module pxc2_mgr (
  input wire logic clock,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = '0;
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge clock) {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = {w, !w, a, d};
    @(negedge clock) {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = {2'h0, ~a, ~d};
  endtask : xfer
endmodule : pxc2_mgr

// ==== tb/pxc2_regs_sva.sv ====
// Purpose: Port checks.
// Assumes: Bound to pxc2_regs.
// Notes: None.
module pxc2_regs_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire logic isolate,
  input wire logic speed_10m,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic tx_pair_high_impedance,
  input wire logic tx_pair_positive_oe_n,
  input wire logic tx_pair_negative_oe_n,
  input wire logic tx100_power_down,
  input wire logic carrier_sense,
  input wire logic collision_sqe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rd_hit; mgmt_rd && mgmt_addr == pxc2_pkg::REG_ADDR; endsequence
  sequence wr_hit; mgmt_wr && mgmt_addr == pxc2_pkg::REG_ADDR; endsequence
  sequence sqe_run; collision_sqe [*4] ##1 !collision_sqe; endsequence
  a_hiz_bit: assert property (wr_hit |->
    ##2 tx_pair_high_impedance == $past(mgmt_wdata[7], 2)) else $error("hiz");
  a_oe_hiz: assert property (wr_hit |-> ##2
    tx_pair_positive_oe_n == $past(mgmt_wdata[7], 2)
    && tx_pair_negative_oe_n == $past(mgmt_wdata[7], 2)) else $error("oe");
  a_rd_ans: assert property (rd_hit |=> mgmt_rvalid && !mgmt_rdata[10])
    else $error("rvalid");
  a_rd_miss: assert property (mgmt_rd && mgmt_addr != pxc2_pkg::REG_ADDR |=>
    !mgmt_rvalid) else $error("miss");
  a_iso_pd: assert property (isolate |=> tx100_power_down) else $error("iso");
  a_pd_speed: assert property (!speed_10m && !isolate |=> !tx100_power_down)
    else $error("pd");
  a_crs_rx: assert property (rx_activity |=> carrier_sense) else $error("crs");
  a_crs_idle: assert property (!rx_activity && !tx_activity |=> !carrier_sense)
    else $error("idle");
  a_sqe_len: assert property ($rose(collision_sqe) |-> sqe_run) else $error("sqe");
endmodule : pxc2_regs_sva
bind pxc2_regs pxc2_regs_sva pxc2_regs_sva_i (.*);

// ==== tb/tb_pxc2_regs.sv ====
// Purpose: Self-checking bench.
// Assumes: Inputs move on falling edges.
// Notes: Each strap setting needs its own reset.
module tb_pxc2_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst_n = 0, node_repeater_strap = 0, pin_register_priority_strap = 0;
  logic partner_remote_fault = 0, isolate = 0, speed_10m = 0, full_duplex = 0;
  logic sqe_inhibit = 0, tx_en = 0, tx_activity = 0, rx_activity = 0, mgmt_wr, mgmt_rd;
  logic mgmt_rvalid, tx_pair_high_impedance, tx_pair_positive_oe_n, tx_pair_negative_oe_n;
  logic tx100_power_down, carrier_sense, collision_sqe;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  int num_errors = 0, cmp_count = 0, cyc = 0, n;
  pxc2_regs pxc2_regs_i (.*);
  pxc2_mgr pxc2_mgr_i (.*);
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    pxc2_mgr_i.xfer(1'b0, a, 16'h0000);
    chk("rvalid", {15'h0000, a == pxc2_pkg::REG_ADDR}, {15'h0000, mgmt_rvalid});
    if (a == pxc2_pkg::REG_ADDR) chk("rdata", e, mgmt_rdata);
  endtask : rd
  task automatic step(input int k);
    repeat (k) @(negedge clock);
  endtask : step
  task automatic sqe_burst(input logic [15:0] e);
    int k;
    k = 0;
    tx_en = 1;
    step(3);
    tx_en = 0;
    repeat (12) begin
      @(negedge clock);
      k += (collision_sqe !== 1'b0);
    end
    chk("sqe", e, k[15:0]);
  endtask : sqe_burst
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    for (int s = 0; s < 2; s++) begin
      {node_repeater_strap, pin_register_priority_strap} = {s[0], !s[0]};
      {partner_remote_fault, speed_10m, rst_n} = 3'h0;
      step(16);
      rst_n = 1;
      step(5);
      rd(5'h13, {s[0], !s[0], 14'h0001});
      rd(5'h12, 16'h0000);
      pxc2_mgr_i.xfer(1'b1, 5'h13, 16'he081);
      rd(5'h13, {s[0], !s[0], 14'h0081});
      chk("hiz", 16'h0007, {13'h0000, tx_pair_high_impedance, tx_pair_positive_oe_n,
        tx_pair_negative_oe_n});
      speed_10m = 1;
      step(2);
      chk("pd", 16'h0001, {15'h0000, tx100_power_down});
      pxc2_mgr_i.xfer(1'b1, 5'h13, 16'h0000);
      step(1);
      chk("pd", 16'h0000, {15'h0000, tx100_power_down});
      chk("hiz", 16'h0000, {13'h0000, tx_pair_high_impedance, tx_pair_positive_oe_n,
        tx_pair_negative_oe_n});
      {isolate, partner_remote_fault} = 2'h3;
      step(4);
      chk("pd", 16'h0001, {15'h0000, tx100_power_down});
      rd(5'h13, {s[0], !s[0], 14'h2000});
      {isolate, tx_activity} = 2'h1;
      step(2);
      chk("crs", {15'h0000, !s[0]}, {15'h0000, carrier_sense});
      {tx_activity, rx_activity, tx_en} = 3'h3;
      step(3);
      {rx_activity, tx_en, n} = '0;
      repeat (12) begin
        @(negedge clock);
        n += (collision_sqe !== 1'b0);
      end
      chk("sqe", s[0] ? 16'h0000 : 16'(pxc2_pkg::SQE_PULSE_CYCLES), n[15:0]);
      sqe_inhibit = 1;
      sqe_burst(16'h0000);
      {sqe_inhibit, full_duplex} = 2'h1;
      sqe_burst(16'h0000);
      full_duplex = 0;
      $display("test %0d done", s);
    end
    summarize();
  end
endmodule : tb_pxc2_regs
